// ==== rtl/ekrd_top.sv ====
// Purpose: Decode key request blocks and report target descriptors
// Assumes: Software loads each structure through the APB windows, then starts
// Notes: One wait-free access phase; read data is captured in the setup cycle
//
// Added by the designer: the APB register port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

// Contract
// - Target descriptor names the verifying enclave
// - Measurement at 0, attributes at 32
// - Control-flow byte valid only with capability
// - Config version 50, misc 52, identity 64
// - Decode selector, policy, software version
// - Control-flow mask used only with capability
// - Processor version at 8, attribute mask 24
// - Wear-out nonce enters key derivation
// - Misc mask selects misc feature bits
// - Field at 76 picks config version
// - Selector values zero to four, rest reserved
// - Policy bits include enclave and signer measurement
// - Policy bit two omits product identifier
// - Policy bits three to five add identities
module ekrd_top (
	input wire logic pclk, // 20 MHz clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [ekrd_pkg::PADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire ekrd_pkg::ekrd_encl_id_t encl_id, // Calling enclave values
	output ekrd_pkg::ekrd_key_req_t key_req, // Decoded derivation inputs
	output logic key_valid, // Key request accepted
	output logic key_err, // Key request refused
	output ekrd_pkg::ekrd_target_t target, // Decoded report target
	output logic target_valid // Target descriptor decoded
);
	import ekrd_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic ekrd_key_kind_t sel_kind(input logic [15:0] sel);
		unique case (sel)
			SEL_LAUNCH_TOKEN: return KIND_LAUNCH_TOKEN;
			SEL_DEV_PROV: return KIND_DEV_PROV;
			SEL_PROV_SEAL: return KIND_PROV_SEAL;
			SEL_REPORT: return KIND_REPORT;
			SEL_SEALING: return KIND_SEALING;
			default: return KIND_RESERVED;
		endcase
	endfunction

	function automatic logic win_hit(input logic [PADDR_W-1:0] a, input logic [PADDR_W-1:0] base,
		input int unsigned words);
		logic [PADDR_W-1:0] top;
		top = base + PADDR_W'(words * 4);
		return (a >= base) && (a < top) && (a[IDX_LSB-1:0] == 2'b00);
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic setup;
	logic wr;
	logic td_hit;
	logic kr_hit;
	logic mapped;
	logic [IDX_W-1:0] idx;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign td_hit = win_hit(paddr, TD_WIN_BASE, TD_WORDS);
	assign kr_hit = win_hit(paddr, KR_WIN_BASE, KR_WORDS);
	assign mapped = td_hit | kr_hit | (paddr == REG_CTRL) | (paddr == REG_STATUS) |
		(paddr == REG_BASE);
	assign idx = paddr[IDX_LSB +: IDX_W];
	assign pready = 1'b1;

	// ----------------------------------------------------------------
	// Structure buffers
	// ----------------------------------------------------------------
	logic [31:0] td_mem_ff [TD_WORDS];
	logic [31:0] kr_mem_ff [KR_WORDS];
	logic [TD_WORDS*32-1:0] td_flat;
	logic [KR_WORDS*32-1:0] kr_flat;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < TD_WORDS; i++) td_mem_ff[i] <= RESET_WORD;
			for (int i = 0; i < KR_WORDS; i++) kr_mem_ff[i] <= RESET_WORD;
		end else if (wr && td_hit) begin
			td_mem_ff[idx] <= pwdata;
		end else if (wr && kr_hit) begin
			kr_mem_ff[idx] <= pwdata;
		end
	end

	always_comb begin
		for (int i = 0; i < TD_WORDS; i++) td_flat[i*32 +: 32] = td_mem_ff[i];
		for (int i = 0; i < KR_WORDS; i++) kr_flat[i*32 +: 32] = kr_mem_ff[i];
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic cap_ff;
	logic go_key_ff;
	logic go_rpt_ff;
	logic [31:0] base_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_ff <= 1'b0;
			base_ff <= RESET_WORD;
		end else if (wr && paddr == REG_CTRL) begin
			cap_ff <= pwdata[CTRL_CAP_BIT];
		end else if (wr && paddr == REG_BASE) begin
			base_ff <= pwdata;
		end
	end

	// Start strobes live one cycle, so a held bit does not retrigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_key_ff <= 1'b0;
			go_rpt_ff <= 1'b0;
		end else begin
			go_key_ff <= wr && paddr == REG_CTRL && pwdata[CTRL_GO_KEY_BIT];
			go_rpt_ff <= wr && paddr == REG_CTRL && pwdata[CTRL_GO_RPT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Key request decode
	// ----------------------------------------------------------------
	logic [15:0] kr_pol;
	logic sel_rsv;
	logic pol_rsv;
	logic align_err;
	logic key_ok;
	ekrd_key_req_t nxt_key;
	assign kr_pol = kr_flat[KR_POL_OFF*8 +: 16];
	assign sel_rsv = sel_kind(kr_flat[KR_SEL_OFF*8 +: 16]) == KIND_RESERVED;
	assign pol_rsv = |kr_pol[15:POL_RSV_LSB];
	// misaligned address is refused rather than trusted
	assign align_err = |base_ff[ALIGN_LSB-1:0];
	assign key_ok = ~sel_rsv & ~pol_rsv & ~align_err;
	always_comb begin
		nxt_key.kind = sel_kind(kr_flat[KR_SEL_OFF*8 +: 16]);
		nxt_key.ssv = kr_flat[KR_SSV_OFF*8 +: 16];
		nxt_key.use_encl_meas = kr_pol[POL_ENCL_MEAS];
		nxt_key.use_signer = kr_pol[POL_SIGNER];
		nxt_key.use_prod_id = ~kr_pol[POL_OMIT_PROD];
		nxt_key.use_cfg_id = kr_pol[POL_CFG_ID];
		nxt_key.use_family = kr_pol[POL_FAMILY];
		nxt_key.use_ext_prod = kr_pol[POL_EXT_PROD];
		nxt_key.cfa_sel = cap_ff ? (kr_flat[KR_CFAM_OFF*8 +: 8] & encl_id.cfa_attr) : 8'h00;
		nxt_key.psv = kr_flat[KR_PSV_OFF*8 +: 128];
		nxt_key.attr_sel = kr_flat[KR_AMASK_OFF*8 +: 128] & encl_id.attributes;
		nxt_key.nonce = kr_flat[KR_NONCE_OFF*8 +: 256];
		nxt_key.misc_sel = kr_flat[KR_MMASK_OFF*8 +: 32] & encl_id.misc_select;
		nxt_key.csvn = kr_flat[KR_CSVN_OFF*8 +: 16];
	end
	ekrd_key_req_t key_req_ff;
	logic key_valid_ff;
	logic key_err_ff;
	// a refused request leaves no key data behind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_req_ff <= '0;
			key_valid_ff <= 1'b0;
			key_err_ff <= 1'b0;
		end else begin
			key_valid_ff <= go_key_ff & key_ok;
			key_err_ff <= go_key_ff & ~key_ok;
			if (go_key_ff) begin
				key_req_ff <= key_ok ? nxt_key : '0;
			end
		end
	end
	assign key_req = key_req_ff;
	assign key_valid = key_valid_ff;
	assign key_err = key_err_ff;

	// ----------------------------------------------------------------
	// Report target decode
	// ----------------------------------------------------------------
	ekrd_target_t nxt_tgt;
	ekrd_target_t target_ff;
	logic target_valid_ff;
	always_comb begin
		nxt_tgt.meas = td_flat[TD_MEAS_OFF*8 +: 256];
		nxt_tgt.attr = td_flat[TD_ATTR_OFF*8 +: 128];
		// reserved byte reads as zero without capability
		nxt_tgt.cfa = cap_ff ? td_flat[TD_CFA_OFF*8 +: 8] : 8'h00;
		// version, misc select and config identity
		nxt_tgt.csvn = td_flat[TD_CSVN_OFF*8 +: 16];
		nxt_tgt.misc = td_flat[TD_MISC_OFF*8 +: 32];
		nxt_tgt.cfgid = td_flat[TD_CFGID_OFF*8 +: 512];
	end
	// misaligned descriptor address yields no target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_ff <= '0;
			target_valid_ff <= 1'b0;
		end else begin
			target_valid_ff <= go_rpt_ff & ~align_err;
			if (go_rpt_ff && !align_err) begin
				target_ff <= nxt_tgt;
			end
		end
	end
	assign target = target_ff;
	assign target_valid = target_valid_ff;

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	logic key_done_ff;
	logic key_bad_ff;
	logic rpt_done_ff;
	logic sel_rsv_ff;
	logic pol_rsv_ff;
	logic align_err_ff;
	ekrd_key_kind_t kind_ff;

	// Flags describe the latest key decode; a new key start overwrites them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_done_ff <= 1'b0;
			key_bad_ff <= 1'b0;
			sel_rsv_ff <= 1'b0;
			pol_rsv_ff <= 1'b0;
			kind_ff <= KIND_LAUNCH_TOKEN;
		end else if (go_key_ff) begin
			key_done_ff <= 1'b1;
			key_bad_ff <= ~key_ok;
			sel_rsv_ff <= sel_rsv;
			pol_rsv_ff <= pol_rsv;
			kind_ff <= nxt_key.kind;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rpt_done_ff <= 1'b0;
			align_err_ff <= 1'b0;
		end else if (go_key_ff || go_rpt_ff) begin
			rpt_done_ff <= go_rpt_ff & ~align_err;
			align_err_ff <= align_err;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic [31:0] prdata_ff;
	logic slverr_ff;
	always_comb begin
		rd_word = RESET_WORD;
		if (td_hit) begin
			rd_word = td_mem_ff[idx];
		end else if (kr_hit) begin
			rd_word = kr_mem_ff[idx];
		end else if (paddr == REG_CTRL) begin
			rd_word[CTRL_CAP_BIT] = cap_ff;
		end else if (paddr == REG_BASE) begin
			rd_word = base_ff;
		end else if (paddr == REG_STATUS) begin
			rd_word[ST_KEY_DONE] = key_done_ff;
			rd_word[ST_KEY_ERR] = key_bad_ff;
			rd_word[ST_RPT_DONE] = rpt_done_ff;
			rd_word[ST_SEL_RSV] = sel_rsv_ff;
			rd_word[ST_POL_RSV] = pol_rsv_ff;
			rd_word[ST_ALIGN_ERR] = align_err_ff;
			rd_word[ST_KIND_LSB +: 3] = kind_ff;
		end
	end
	// Captured in setup so the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= RESET_WORD;
			slverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff <= pwrite ? RESET_WORD : rd_word;
			slverr_ff <= ~mapped;
		end
	end
	assign prdata = prdata_ff;
	assign pslverr = slverr_ff & psel & penable;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_sel_rsv_err;
		go_key_ff && sel_rsv |=> key_err && !key_valid && key_req == '0;
	endproperty
	a_sel_rsv_err: assert property (p_sel_rsv_err) else $error("reserved selector accepted");
	property p_pol_rsv_err;
		go_key_ff && pol_rsv |=> key_err ##1 !key_err;
	endproperty
	a_pol_rsv_err: assert property (p_pol_rsv_err) else $error("reserved policy accepted");
	property p_key_follows_go;
		key_valid |-> $past(go_key_ff) && key_req.ssv == $past(kr_flat[KR_SSV_OFF*8 +: 16]);
	endproperty
	a_key_follows_go: assert property (p_key_follows_go) else $error("key without start");
	property p_meas_sel;
		key_valid |-> key_req.use_encl_meas == $past(kr_pol[POL_ENCL_MEAS]) &&
			key_req.use_signer == $past(kr_pol[POL_SIGNER]);
	endproperty
	a_meas_sel: assert property (p_meas_sel) else $error("measurement selection wrong");
	property p_omit_prod;
		key_valid |-> key_req.use_prod_id != $past(kr_pol[POL_OMIT_PROD]);
	endproperty
	a_omit_prod: assert property (p_omit_prod) else $error("product id selection wrong");
	property p_cfa_gate;
		key_valid && !$past(cap_ff) |-> key_req.cfa_sel == 8'h00;
	endproperty
	a_cfa_gate: assert property (p_cfa_gate) else $error("mask used without capability");
	property p_nonce;
		key_valid |-> key_req.nonce == $past(kr_flat[KR_NONCE_OFF*8 +: 256]);
	endproperty
	a_nonce: assert property (p_nonce) else $error("nonce not carried");
	property p_misc;
		key_valid |-> key_req.misc_sel ==
			($past(kr_flat[KR_MMASK_OFF*8 +: 32]) & $past(encl_id.misc_select));
	endproperty
	a_misc: assert property (p_misc) else $error("misc masking wrong");
	property p_tgt;
		go_rpt_ff && !align_err |=> target_valid && target.meas == $past(td_flat[255:0]) &&
			(cap_ff || target.cfa == 8'h00);
	endproperty
	a_tgt: assert property (p_tgt) else $error("target decode wrong");

	c_key_ok: cover property (go_key_ff && key_ok ##1 key_valid);
	c_key_bad: cover property (go_key_ff && sel_rsv ##1 key_err);
	c_target: cover property (go_rpt_ff ##1 target_valid && cap_ff);

endmodule // ekrd_top

`default_nettype wire

// ==== inc/ekrd_pkg.sv ====
// Purpose: Shared constants and carriers for the enclave key request decoder
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Structure field offsets are byte offsets inside each in-memory structure

package ekrd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned PADDR_W = 12;
	localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
	localparam logic [PADDR_W-1:0] REG_BASE = 12'h008;
	localparam logic [PADDR_W-1:0] TD_WIN_BASE = 12'h100;
	localparam logic [PADDR_W-1:0] KR_WIN_BASE = 12'h200;
	localparam int unsigned TD_WORDS = 32;
	localparam int unsigned KR_WORDS = 20;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_W = 5;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// Control and status bit positions
	localparam int unsigned CTRL_CAP_BIT = 0;
	localparam int unsigned CTRL_GO_KEY_BIT = 1;
	localparam int unsigned CTRL_GO_RPT_BIT = 2;
	localparam int unsigned ST_KEY_DONE = 0;
	localparam int unsigned ST_KEY_ERR = 1;
	localparam int unsigned ST_RPT_DONE = 2;
	localparam int unsigned ST_SEL_RSV = 3;
	localparam int unsigned ST_POL_RSV = 4;
	localparam int unsigned ST_ALIGN_ERR = 5;
	localparam int unsigned ST_KIND_LSB = 8;

	// Structures sit on 512-byte boundaries
	localparam int unsigned ALIGN_LSB = 9;

	// ----------------------------------------------------------------
	// Key request block field byte offsets
	// ----------------------------------------------------------------
	localparam int unsigned KR_SEL_OFF = 0;
	localparam int unsigned KR_POL_OFF = 2;
	localparam int unsigned KR_SSV_OFF = 4;
	localparam int unsigned KR_CFAM_OFF = 6;
	localparam int unsigned KR_PSV_OFF = 8;
	localparam int unsigned KR_AMASK_OFF = 24;
	localparam int unsigned KR_NONCE_OFF = 40;
	localparam int unsigned KR_MMASK_OFF = 72;
	localparam int unsigned KR_CSVN_OFF = 76;

	// Report target descriptor field byte offsets
	localparam int unsigned TD_MEAS_OFF = 0;
	localparam int unsigned TD_ATTR_OFF = 32;
	localparam int unsigned TD_CFA_OFF = 48;
	localparam int unsigned TD_CSVN_OFF = 50;
	localparam int unsigned TD_MISC_OFF = 52;
	localparam int unsigned TD_CFGID_OFF = 64;

	// Derivation policy bits
	localparam int unsigned POL_ENCL_MEAS = 0;
	localparam int unsigned POL_SIGNER = 1;
	localparam int unsigned POL_OMIT_PROD = 2;
	localparam int unsigned POL_CFG_ID = 3;
	localparam int unsigned POL_FAMILY = 4;
	localparam int unsigned POL_EXT_PROD = 5;
	localparam int unsigned POL_RSV_LSB = 6;

	// Key selector values
	localparam logic [15:0] SEL_LAUNCH_TOKEN = 16'h0000;
	localparam logic [15:0] SEL_DEV_PROV = 16'h0001;
	localparam logic [15:0] SEL_PROV_SEAL = 16'h0002;
	localparam logic [15:0] SEL_REPORT = 16'h0003;
	localparam logic [15:0] SEL_SEALING = 16'h0004;

	typedef enum logic [2:0] {
		KIND_LAUNCH_TOKEN,
		KIND_DEV_PROV,
		KIND_PROV_SEAL,
		KIND_REPORT,
		KIND_SEALING,
		KIND_RESERVED
	} ekrd_key_kind_t;

	typedef struct packed {
		logic [127:0] attributes;
		logic [31:0] misc_select;
		logic [7:0] cfa_attr;
	} ekrd_encl_id_t;

	typedef struct packed {
		ekrd_key_kind_t kind;
		logic use_encl_meas;
		logic use_signer;
		logic use_prod_id;
		logic use_cfg_id;
		logic use_family;
		logic use_ext_prod;
		logic [15:0] ssv;
		logic [7:0] cfa_sel;
		logic [127:0] psv;
		logic [127:0] attr_sel;
		logic [255:0] nonce;
		logic [31:0] misc_sel;
		logic [15:0] csvn;
	} ekrd_key_req_t;

	typedef struct packed {
		logic [255:0] meas;
		logic [127:0] attr;
		logic [7:0] cfa;
		logic [15:0] csvn;
		logic [31:0] misc;
		logic [511:0] cfgid;
	} ekrd_target_t;

endpackage

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the enclave key request decoder
// Assumes: Zero-wait APB slave, decode pulses two edges after the start write
// Notes: Driver queues expected pulses, a monitor pops them as they appear
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ekrd_pkg::*;
	localparam int NW = 3 + $bits(ekrd_key_req_t) + $bits(ekrd_target_t);
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic key_valid, key_err, target_valid, err;
	logic [PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, seed, rd;
	ekrd_encl_id_t encl_id;
	ekrd_key_req_t key_req, ek;
	ekrd_target_t target, et;
	logic [7:0] kb [0:127];
	logic [7:0] db [0:127];
	logic [15:0] sels [0:7] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'hffff, 16'h3};
	logic [NW-1:0] q [$];
	int mismatches, n_tests;

	ekrd_top ekrd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .encl_id(encl_id), .key_req(key_req), .key_valid(key_valid),
		.key_err(key_err), .target(target), .target_valid(target_valid));

	always #25 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Little-endian field out of a structure image
	function automatic logic [511:0] fld(input logic [7:0] b [0:127], input int off, input int n);
		logic [511:0] r;
		r = '0;
		for (int k = 0; k < n; k++) r[8*k+:8] = b[off+k];
		return r;
	endfunction

	task automatic chk(input logic [NW-1:0] g, input logic [NW-1:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Master holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d,
		output logic e);
		int n;
		logic ok;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		ok = (pready === 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (!ok) begin
			mismatches++;
			finish_test();
		end
	endtask

	task automatic rdchk(input logic [PADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
		logic se;
		apb(1'b0, a, 32'h0, se);
		chk(NW'({se, rd & m}), NW'({1'b0, e & m}));
	endtask

	task automatic load(input logic [PADDR_W-1:0] base, input int words, input logic kr);
		logic se;
		for (int w = 0; w < words; w++)
			apb(1'b1, base + PADDR_W'(4*w), kr ? {kb[4*w+3], kb[4*w+2], kb[4*w+1], kb[4*w]} :
				{db[4*w+3], db[4*w+2], db[4*w+1], db[4*w]}, se);
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (q.size() != 0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (q.size() != 0) begin
			mismatches++;
			finish_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Reference decode and start
	// ----------------------------------------------------------------
	task automatic run(input logic cap, input logic gk, input logic gt, input logic mis);
		logic [15:0] sel, pol;
		logic kerr, se;
		sel = 16'(fld(kb, 0, 2));
		pol = 16'(fld(kb, 2, 2));
		kerr = sel > 16'h4 || pol[15:6] != 10'h0 || mis;
		if (gk) begin
			ek.kind = sel <= 16'h4 ? ekrd_key_kind_t'(sel[2:0]) : KIND_RESERVED;
			ek.use_encl_meas = pol[0];
			ek.use_signer = pol[1];
			ek.use_prod_id = ~pol[2];
			ek.use_cfg_id = pol[3];
			ek.use_family = pol[4];
			ek.use_ext_prod = pol[5];
			ek.ssv = 16'(fld(kb, 4, 2));
			ek.cfa_sel = cap ? kb[6] & encl_id.cfa_attr : 8'h0;
			ek.psv = 128'(fld(kb, 8, 16));
			ek.attr_sel = 128'(fld(kb, 24, 16)) & encl_id.attributes;
			ek.nonce = 256'(fld(kb, 40, 32));
			ek.misc_sel = 32'(fld(kb, 72, 4)) & encl_id.misc_select;
			ek.csvn = 16'(fld(kb, 76, 2));
			if (kerr) ek = '0;
		end
		if (gt && !mis) begin
			et.meas = 256'(fld(db, 0, 32));
			et.attr = 128'(fld(db, 32, 16));
			et.cfa = cap ? db[48] : 8'h0;
			et.csvn = 16'(fld(db, 50, 2));
			et.misc = 32'(fld(db, 52, 4));
			et.cfgid = fld(db, 64, 64);
		end
		if (gk || (gt && !mis)) q.push_back({gk && !kerr, gk && kerr, gt && !mis, ek, et});
		apb(1'b1, REG_CTRL, {29'h0, gt, gk, cap}, se);
		drain();
		rdchk(REG_STATUS, {21'h0, sel[2:0], 2'b0, mis, pol[15:6] != 10'h0, sel > 16'h4,
			gt && !mis, gk && kerr, gk},
			{21'h0, {3{gk && !kerr}}, 2'b0, 1'b1, {2{gk}}, gt, {2{gk}}});
		rdchk(REG_CTRL, {31'h0, cap}, 32'hffffffff);
	endtask

	// ----------------------------------------------------------------
	// Monitor
	// ----------------------------------------------------------------
	always @(negedge pclk) begin
		if (presetn && (key_valid | key_err | target_valid)) begin
			if (q.size() == 0) chk(NW'({key_valid, key_err, target_valid}), NW'(0));
			else chk({key_valid, key_err, target_valid, key_req, target}, q.pop_front());
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		encl_id = '0;
		seed = 32'd16383;
		mismatches = 0;
		n_tests = 0;
		ek = '0;
		et = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(REG_STATUS, 32'h0, 32'hffffffff);
		rdchk(REG_CTRL, 32'h0, 32'hffffffff);
		apb(1'b0, 12'hffc, 32'h0, err);
		chk(NW'({err, rd}), NW'({1'b1, 32'h0}));
		apb(1'b1, REG_BASE, 32'h0000_4200, err);
		rdchk(REG_BASE, 32'h0000_4200, 32'hffffffff);
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 128; k++) begin
				kb[k] = 8'(rnd());
				db[k] = 8'(rnd());
			end
			encl_id <= {rnd(), rnd(), rnd(), rnd(), rnd(), 8'(rnd())};
			{kb[1], kb[0]} = sels[i];
			kb[2] = {2'b0, kb[2][5:0]};
			// reserved policy bits zero except on pass 7, where a policy refusal is wanted
			kb[3] = i == 7 ? 8'h80 : 8'h0;
			if (!i[0]) kb[6] = 8'h0;
			kb[7] = 8'h0;
			kb[78] = 8'h0;
			kb[79] = 8'h0;
			db[49] = 8'h0;
			for (int k = 56; k < 64; k++) db[k] = 8'h0;
			load(KR_WIN_BASE, KR_WORDS, 1'b1);
			load(TD_WIN_BASE, TD_WORDS, 1'b0);
			rdchk(KR_WIN_BASE, {kb[3], kb[2], kb[1], kb[0]}, 32'hffffffff);
			rdchk(TD_WIN_BASE + 12'h030, {db[51], db[50], db[49], db[48]}, 32'hffffffff);
			run(i[0], 1'b1, i == 3 || i == 6, 1'b0);
			if (i == 4) run(1'b0, 1'b0, 1'b1, 1'b0);
		end
		apb(1'b1, REG_BASE, 32'h0000_4204, err);
		run(1'b1, 1'b1, 1'b0, 1'b1);
		run(1'b1, 1'b0, 1'b1, 1'b1);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
